// >>> verilog/ccwr_pkg.sv
// Contract
// - Drive strength bits 7,6,1,0; 1 means low (bit 0 counts only in alternate processor mode).
// - Ratio field picks default, 2/1, 2.5/1, 3/1.
// - Reference outputs run on 1, stop low on 0.
// - Threshold bit chooses voltage per memory mode.
// - Feedback and six pair enables; 0 stops low.
// - Shared pin: 1 power-down input, 0 reset output.
// - Revert bit picks strap or older software frequency.
// - Alarm sets on expiry, clears with timeout field.
// - Timeout code: zero off, else N seconds.
// - Seven divider bits load PLL N, bit 6 MSB.
// - Select bit takes N from ROM or registers.
// - Expiry pulses reset, sets alarm, restarts; reverts later.
// - Writing zero timeout stops timer, clears alarm (an expiry in the same cycle keeps it set).
package ccwr_pkg;

  // Byte offsets of the register bank.
  localparam logic [7:0] PERIPH_OFF = 8'h04;
  localparam logic [7:0] MEM_OFF    = 8'h05;
  localparam logic [7:0] WDOG_OFF   = 8'h06;
  localparam logic [7:0] NDIV_OFF   = 8'h07;

  // Values after reset.
  localparam logic [7:0] PERIPH_RST = 8'hCF;
  localparam logic [7:0] MEM_RST    = 8'h7F;
  localparam logic [7:0] WDOG_RST   = 8'h00;
  localparam logic [7:0] NDIV_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Field positions.
  localparam int USB_DRV_BIT   = 7;
  localparam int SIO_DRV_BIT   = 6;
  localparam int RATIO_LSB     = 4;
  localparam int REF_A_EN_BIT  = 3;
  localparam int REF_B_EN_BIT  = 2;
  localparam int REF_A_DRV_BIT = 1;
  localparam int REF_B_DRV_BIT = 0;
  localparam int THRESH_BIT    = 7;
  localparam int FB_EN_BIT     = 6;
  localparam int ROLE_BIT      = 7;
  localparam int REVERT_BIT    = 6;
  localparam int WATCHDOG_FACTORY_TEST_BIT    = 5;
  localparam int ALARM_BIT     = 4;
  localparam int NDIV_RSV_BIT  = 7;

  // Watchdog timing: one-second tick at the 200 MHz reference.
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned WD_TICK_S      = 1;
  localparam int unsigned WD_TICK_CYCLES = WD_TICK_S * CLK_HZ;
  localparam int unsigned RST_PULSE_CYCLES = 8;
  localparam logic [3:0]  RST_PULSE_LOAD = 4'h8;

  // Buffer input threshold selection as seen by the analog side.
  typedef enum logic [1:0] {
    CCWR_TH_DDR_1V15,
    CCWR_TH_DDR_1V05,
    CCWR_TH_SDR_1V35,
    CCWR_TH_SDR_1V25
  } ccwr_thresh_t;

  // Watchdog states.
  typedef enum logic [1:0] {
    CCWR_WD_OFF,
    CCWR_WD_ARMED,
    CCWR_WD_RUN
  } ccwr_wd_state_t;

endpackage

// >>> verilog/ccwr_watchdog.sv
`timescale 1ns/100ps
module ccwr_watchdog #(
  parameter int unsigned TICK_CYCLES = ccwr_pkg::WD_TICK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] timeout_i,
  input  wire logic       freq_change_i,
  output logic            expire_o,
  output logic            revert_o,
  output logic            reset_pulse_o,
  output logic            running_o
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  ccwr_pkg::ccwr_wd_state_t state;
  logic [TW-1:0] tick_cnt;
  logic [3:0]    sec_cnt;
  logic          expired_once;
  logic [3:0]    pulse_cnt;
  logic          sec_tick;

  assign sec_tick  = (state == ccwr_pkg::CCWR_WD_RUN) && (tick_cnt == TICK_LAST);
  assign expire_o  = sec_tick && ((sec_cnt + 4'h1) == timeout_i);
  assign revert_o  = expire_o && expired_once;
  assign running_o = (state == ccwr_pkg::CCWR_WD_RUN);
  assign reset_pulse_o = (pulse_cnt != 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Arming: a zero code stops the timer at once, a frequency change starts.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ccwr_pkg::CCWR_WD_OFF;
    end else if (timeout_i == 4'h0) begin
      state <= ccwr_pkg::CCWR_WD_OFF;
    end else begin
      case (state)
        ccwr_pkg::CCWR_WD_OFF:   state <= ccwr_pkg::CCWR_WD_ARMED;
        ccwr_pkg::CCWR_WD_ARMED: begin
          if (freq_change_i) begin
            state <= ccwr_pkg::CCWR_WD_RUN;
          end
        end
        ccwr_pkg::CCWR_WD_RUN:   state <= ccwr_pkg::CCWR_WD_RUN;
        default:                 state <= ccwr_pkg::CCWR_WD_OFF;
      endcase
    end
  end

  // One-second prescaler and seconds count; restarts after each expiry.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      sec_cnt  <= 4'h0;
    end else if (state != ccwr_pkg::CCWR_WD_RUN) begin
      tick_cnt <= '0;
      sec_cnt  <= 4'h0;
    end else if (sec_tick) begin
      tick_cnt <= '0;
      sec_cnt  <= expire_o ? 4'h0 : sec_cnt + 4'h1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Remembers a first expiry so that only later ones restore the frequency.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      expired_once <= 1'b0;
    end else if (state == ccwr_pkg::CCWR_WD_OFF) begin
      expired_once <= 1'b0;
    end else if (expire_o) begin
      expired_once <= 1'b1;
    end
  end

  // Reset pulse stretcher; a new expiry reloads it.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_cnt <= 4'h0;
    end else if (expire_o) begin
      pulse_cnt <= ccwr_pkg::RST_PULSE_LOAD;
    end else if (pulse_cnt != 4'h0) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_pulse_train;
    reset_pulse_o [*8];
  endsequence

  property p_pulse_after_expire;
    expire_o |=> s_pulse_train;
  endproperty
  a_pulse_after_expire: assert property (p_pulse_after_expire)
    else $error("reset pulse shorter than expected");

  property p_zero_stops;
    timeout_i == 4'h0 |=> !running_o && !expire_o;
  endproperty
  a_zero_stops: assert property (p_zero_stops)
    else $error("watchdog kept running with zero timeout");

  // A freshly started timer must not remember an expiry of an earlier run.
  property p_first_no_revert;
    $rose(running_o) |-> !expired_once && !revert_o;
  endproperty
  a_first_no_revert: assert property (p_first_no_revert)
    else $error("frequency restored on first expiry");

endmodule // ccwr_watchdog

// >>> verilog/ccwr_regs.sv
`timescale 1ns/100ps
module ccwr_regs #(
  parameter int unsigned WD_TICK_CYCLES = ccwr_pkg::WD_TICK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       cpu_alt_mode_i,
  input  wire logic       ddr_mode_i,
  input  wire logic       freq_change_i,
  input  wire logic       divider_source_select_i,
  input  wire logic [6:0] rom_n_i,
  input  wire logic       shared_pin_i,
  output logic            system_reset_out_n_o,
  output logic            system_reset_out_n_oe_o,
  output logic            power_down_in_n_o,
  output logic            usb_clock_out_low_drv_o,
  output logic            superio_clock_out_low_drv_o,
  output logic            reference_out_a_low_drv_o,
  output logic            reference_out_b_low_drv_o,
  output logic            reference_out_a_en_o,
  output logic            reference_out_b_en_o,
  output logic      [1:0] bus_ratio_select_o,
  output ccwr_pkg::ccwr_thresh_t buf_threshold_o,
  output logic            feedback_clock_out_en_o,
  output logic      [5:0] memory_clock_pair_en_o,
  output logic            revert_to_software_o,
  output logic            revert_freq_o,
  output logic            watchdog_timeout_flag_o,
  output logic      [6:0] pll_feedback_divider_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths.
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  logic [7:0] periph_clock_control;
  logic [7:0] memory_clock_control;
  logic [7:0] watchdog_control;
  logic [7:0] pll_n_divider;
  logic       watchdog_timeout_flag;
  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic       cpu_alt_mode;
  logic       ddr_mode;
  logic       shared_pin;
  logic       wd_expire;
  logic       wd_revert;
  logic       wd_reset_pulse;
  logic       wd_running;
  logic       wr_periph;
  logic       wr_mem;
  logic       wr_wdog;
  logic       wr_ndiv;
  logic       alarm_clear;

  assign wr_periph = reg_wr_i && reg_hit(reg_addr_i, ccwr_pkg::PERIPH_OFF);
  assign wr_mem    = reg_wr_i && reg_hit(reg_addr_i, ccwr_pkg::MEM_OFF);
  assign wr_wdog   = reg_wr_i && reg_hit(reg_addr_i, ccwr_pkg::WDOG_OFF);
  assign wr_ndiv   = reg_wr_i && reg_hit(reg_addr_i, ccwr_pkg::NDIV_OFF);
  assign alarm_clear = wr_wdog && (reg_wdata_i[3:0] == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Straps and the shared pin come from outside; two flops before use.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_meta <= 3'h0;
      sync_q    <= 3'h0;
    end else begin
      sync_meta <= {shared_pin_i, ddr_mode_i, cpu_alt_mode_i};
      sync_q    <= sync_meta;
    end
  end

  assign cpu_alt_mode = sync_q[0];
  assign ddr_mode     = sync_q[1];
  assign shared_pin   = sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral clock byte: drive strengths, ratio and reference enables.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      periph_clock_control <= ccwr_pkg::PERIPH_RST;
    end else if (wr_periph) begin
      periph_clock_control <= reg_wdata_i;
    end
  end

  // Memory clock byte: threshold choice and output enables.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      memory_clock_control <= ccwr_pkg::MEM_RST;
    end else if (wr_mem) begin
      memory_clock_control <= reg_wdata_i;
    end
  end

  // Watchdog byte; the alarm position is kept by its own flop below.
  // The factory test bit is stored as written; software must keep it 0.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_control <= ccwr_pkg::WDOG_RST;
    end else if (wr_wdog) begin
      watchdog_control <= reg_wdata_i;
    end
  end

  // Divider byte; the reserved top bit is stored but steers nothing.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_n_divider <= ccwr_pkg::NDIV_RST;
    end else if (wr_ndiv) begin
      pll_n_divider <= reg_wdata_i;
    end
  end

  // Alarm flag: only the watchdog sets it, a zero timeout write clears it.
  // An expiry in the same cycle as the clear wins so no event is lost.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wd_expire) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (alarm_clear) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog timer with its one-second prescaler.
  ccwr_watchdog #(
    .TICK_CYCLES (WD_TICK_CYCLES)
  ) u_watchdog (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .timeout_i     (watchdog_control[3:0]),
    .freq_change_i (freq_change_i),
    .expire_o      (wd_expire),
    .revert_o      (wd_revert),
    .reset_pulse_o (wd_reset_pulse),
    .running_o     (wd_running)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data one cycle after the strobe, unmapped reads 0.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= ccwr_pkg::UNMAPPED_RD;
    end else if (reg_rd_i) begin
      if (reg_hit(reg_addr_i, ccwr_pkg::PERIPH_OFF)) begin
        reg_rdata_o <= periph_clock_control;
      end else if (reg_hit(reg_addr_i, ccwr_pkg::MEM_OFF)) begin
        reg_rdata_o <= memory_clock_control;
      end else if (reg_hit(reg_addr_i, ccwr_pkg::WDOG_OFF)) begin
        reg_rdata_o <= {watchdog_control[7:5], watchdog_timeout_flag,
                        watchdog_control[3:0]};
      end else if (reg_hit(reg_addr_i, ccwr_pkg::NDIV_OFF)) begin
        reg_rdata_o <= pll_n_divider;
      end else begin
        reg_rdata_o <= ccwr_pkg::UNMAPPED_RD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive strengths; the second reference bit only counts in the alternate
  // processor mode, elsewhere that output stays at high strength.
  assign usb_clock_out_low_drv_o =
    periph_clock_control[ccwr_pkg::USB_DRV_BIT];
  assign superio_clock_out_low_drv_o =
    periph_clock_control[ccwr_pkg::SIO_DRV_BIT];
  assign reference_out_a_low_drv_o =
    periph_clock_control[ccwr_pkg::REF_A_DRV_BIT];
  assign reference_out_b_low_drv_o = cpu_alt_mode &&
    periph_clock_control[ccwr_pkg::REF_B_DRV_BIT];

  // Ratio code goes straight to the divider chain; 00 defers to straps.
  assign bus_ratio_select_o =
    periph_clock_control[ccwr_pkg::RATIO_LSB +: 2];

  // Enables gate the clock buffers directly, so a stop is asynchronous.
  assign reference_out_a_en_o =
    periph_clock_control[ccwr_pkg::REF_A_EN_BIT];
  assign reference_out_b_en_o =
    periph_clock_control[ccwr_pkg::REF_B_EN_BIT];
  assign feedback_clock_out_en_o =
    memory_clock_control[ccwr_pkg::FB_EN_BIT];
  assign memory_clock_pair_en_o = memory_clock_control[5:0];

  // Threshold: memory mode picks the voltage pair, the bit picks within it.
  assign buf_threshold_o = ccwr_pkg::ccwr_thresh_t'(
    {~ddr_mode, memory_clock_control[ccwr_pkg::THRESH_BIT]});

  // Shared pin: driven as reset output only in that role, else an input.
  assign system_reset_out_n_oe_o =
    ~watchdog_control[ccwr_pkg::ROLE_BIT];
  assign system_reset_out_n_o = ~wd_reset_pulse;
  assign power_down_in_n_o =
    watchdog_control[ccwr_pkg::ROLE_BIT] ? shared_pin : 1'b1;

  // Revert choice and strobe towards the frequency-select logic.
  assign revert_to_software_o =
    watchdog_control[ccwr_pkg::REVERT_BIT];
  assign revert_freq_o = wd_revert;
  assign watchdog_timeout_flag_o = watchdog_timeout_flag;

  // N value: registers or ROM; other clocks keep their ratio to the CPU.
  assign pll_feedback_divider_o = divider_source_select_i ?
    pll_n_divider[6:0] : rom_n_i;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_drive_write;
    wr_periph |=> usb_clock_out_low_drv_o == $past(reg_wdata_i[7]) &&
      superio_clock_out_low_drv_o == $past(reg_wdata_i[6]);
  endproperty
  a_drive_write: assert property (p_drive_write)
    else $error("drive strength not taken from write");

  property p_ratio_write;
    wr_periph |=> bus_ratio_select_o == $past(reg_wdata_i[5:4]);
  endproperty
  a_ratio_write: assert property (p_ratio_write)
    else $error("ratio field not taken from write");

  property p_ref_en_write;
    wr_periph |=> {reference_out_a_en_o, reference_out_b_en_o} ==
      $past(reg_wdata_i[3:2]);
  endproperty
  a_ref_en_write: assert property (p_ref_en_write)
    else $error("reference enables not taken from write");

  property p_mem_en_write;
    wr_mem |=> {feedback_clock_out_en_o, memory_clock_pair_en_o} ==
      $past(reg_wdata_i[6:0]);
  endproperty
  a_mem_en_write: assert property (p_mem_en_write)
    else $error("memory clock enables not taken from write");

  property p_alarm_set;
    wd_expire |=> watchdog_timeout_flag_o;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm not set on expiry");

  property p_alarm_clear;
    alarm_clear && !wd_expire |=> !watchdog_timeout_flag_o ##1 !wd_running;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("zero timeout did not clear alarm and stop timer");

  property p_alarm_hold;
    !wd_expire && !alarm_clear |=> $stable(watchdog_timeout_flag_o);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm changed without cause");

  property p_ndiv_load;
    wr_ndiv && divider_source_select_i ##1 divider_source_select_i
      |-> pll_feedback_divider_o == $past(reg_wdata_i[6:0]);
  endproperty
  a_ndiv_load: assert property (p_ndiv_load)
    else $error("divider value not loaded from register");

  property p_pin_role;
    wd_expire && !watchdog_control[ccwr_pkg::ROLE_BIT] && !wr_wdog |=>
      system_reset_out_n_oe_o && !system_reset_out_n_o;
  endproperty
  a_pin_role: assert property (p_pin_role)
    else $error("reset pulse not driven on shared pin");

  // In the input role the pin is never driven and its level feeds power-down.
  property p_pin_input_role;
    watchdog_control[ccwr_pkg::ROLE_BIT] |->
      !system_reset_out_n_oe_o && power_down_in_n_o == shared_pin;
  endproperty
  a_pin_input_role: assert property (p_pin_input_role)
    else $error("shared pin driven while in input role");

  property p_revert_write;
    wr_wdog |=> revert_to_software_o ==
      $past(reg_wdata_i[ccwr_pkg::REVERT_BIT]);
  endproperty
  a_revert_write: assert property (p_revert_write)
    else $error("revert choice not taken from write");

  property p_alarm_readback;
    reg_rd_i && reg_hit(reg_addr_i, ccwr_pkg::WDOG_OFF) |=>
      reg_rdata_o[ccwr_pkg::ALARM_BIT] == $past(watchdog_timeout_flag);
  endproperty
  a_alarm_readback: assert property (p_alarm_readback)
    else $error("alarm flag not returned by read");

  // Reads outside the bank must never leak a stored byte.
  property p_unmapped_read;
    reg_rd_i && (reg_addr_i < ccwr_pkg::PERIPH_OFF ||
      reg_addr_i > ccwr_pkg::NDIV_OFF) |=>
      reg_rdata_o == ccwr_pkg::UNMAPPED_RD;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");

endmodule // ccwr_regs

// >>> testbench/ccwr_host_model.sv
`timescale 1ns/100ps
// Firmware-side host that issues single-byte accesses on the strobe port.
module ccwr_host_model (
  input  wire logic       clk_sys_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);

  // Strobes start low so nothing is taken before reset ends.
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // One byte write; factory test bits always go out as zero.
  // Address and data are inverted once released, so a design that
  // latches them outside the strobe shows a wrong value.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == ccwr_pkg::WDOG_OFF) begin
      d[ccwr_pkg::WATCHDOG_FACTORY_TEST_BIT] = 1'b0;
    end
    if (addr == ccwr_pkg::NDIV_OFF) begin
      d[ccwr_pkg::NDIV_RSV_BIT] = 1'b0;
    end
    @(negedge clk_sys_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = d;
    @(negedge clk_sys_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~d;
  endtask

  // One byte read; data is taken a cycle after the strobe.
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = addr;
    @(negedge clk_sys_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask

endmodule // ccwr_host_model

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int unsigned TICK = 16;
  logic       clk_sys_i, sys_rst_i, reg_wr, reg_rd;
  logic       alt, ddr, freq, dsel, pin;
  logic       rst_n, rst_oe, pd_n, usb_drv, sio_drv, refa_drv, refb_drv;
  logic       refa_en, refb_en, fb_en, rev_sw, rev_pulse, flag;
  logic [1:0] ratio;
  logic [3:0] code;
  logic [5:0] pair_en;
  logic [6:0] rom_n, pll_n;
  logic [7:0] addr, wdata, rdata, rb;
  ccwr_pkg::ccwr_thresh_t thresh;
  int         num_errors, n_compared, rv_cnt, falls, cnt;
  int         rv_base, fall_base;
  logic [7:0] vals  [4] = '{8'h00, 8'hFF, 8'h9A, 8'h65};
  logic [7:0] rst_v [4] = '{ccwr_pkg::PERIPH_RST, ccwr_pkg::MEM_RST,
                            ccwr_pkg::WDOG_RST, ccwr_pkg::NDIV_RST};

  ccwr_host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata));

  ccwr_regs #(.WD_TICK_CYCLES(TICK)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .cpu_alt_mode_i(alt), .ddr_mode_i(ddr),
    .freq_change_i(freq), .divider_source_select_i(dsel),
    .rom_n_i(rom_n), .shared_pin_i(pin),
    .system_reset_out_n_o(rst_n), .system_reset_out_n_oe_o(rst_oe),
    .power_down_in_n_o(pd_n), .usb_clock_out_low_drv_o(usb_drv),
    .superio_clock_out_low_drv_o(sio_drv),
    .reference_out_a_low_drv_o(refa_drv),
    .reference_out_b_low_drv_o(refb_drv),
    .reference_out_a_en_o(refa_en), .reference_out_b_en_o(refb_en),
    .bus_ratio_select_o(ratio), .buf_threshold_o(thresh),
    .feedback_clock_out_en_o(fb_en), .memory_clock_pair_en_o(pair_en),
    .revert_to_software_o(rev_sw), .revert_freq_o(rev_pulse),
    .watchdog_timeout_flag_o(flag), .pll_feedback_divider_o(pll_n));

  // Clock toggles every half period of 2.5 ns.
  initial clk_sys_i = 1'b0;
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Revert pulses and reset pin falls are counted as they happen.
  always @(negedge clk_sys_i) if (rev_pulse === 1'b1) rv_cnt++;
  always @(negedge rst_n) falls++;

  ////////////////////////////////////////////////////////////
  // Byte compare; unknowns never match.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycle count compare against a window.
  task automatic chk_in(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  // Strap inputs pass two sync flops before they count.
  task automatic settle;
    repeat (3) @(negedge clk_sys_i);
  endtask

  // Waits for a reset pin pulse, then checks its timing and length.
  task automatic wd_expiry(input int exp);
    cnt = 0;
    while (rst_n !== 1'b0 && cnt < 400) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    chk_in(cnt, exp - 1, exp + 2);
    chk({7'h00, flag}, 8'h01);
    cnt = 0;
    while (rst_n === 1'b0 && cnt < 40) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    chk_in(cnt, 8, 8);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    num_errors++;
    $display("Timeout at %0t", $time);
    final_report();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    sys_rst_i = 1'b1;
    {alt, ddr, freq, dsel} = 4'h0;
    pin   = 1'b1;
    rom_n = 7'h2B;
    repeat (5) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(i + 4), rb);
      chk(rb, rst_v[i]);
    end
    host.wr(8'h03, 8'h55);
    host.rd(8'h03, rb);
    chk(rb, ccwr_pkg::UNMAPPED_RD);
    chk({refa_en, refb_en, fb_en, rst_oe, rst_n, pd_n, flag, rev_sw},
        8'hFC);
    chk({2'b00, pair_en}, 8'h3F);
    $display("test reset done");

    // Peripheral byte, alternate mode on, then off.
    alt = 1'b1;
    settle();
    foreach (vals[i]) begin
      host.wr(ccwr_pkg::PERIPH_OFF, vals[i]);
      chk({usb_drv, sio_drv, ratio, refa_en, refb_en, refa_drv, refb_drv},
          vals[i]);
      host.rd(ccwr_pkg::PERIPH_OFF, rb);
      chk(rb, vals[i]);
    end
    alt = 1'b0;
    settle();
    chk({7'h00, refb_drv}, 8'h00);
    $display("test peripheral done");

    // Memory byte in both memory modes.
    for (int d = 0; d < 2; d++) begin
      ddr = d[0];
      settle();
      foreach (vals[i]) begin
        host.wr(ccwr_pkg::MEM_OFF, vals[i]);
        chk({6'h00, thresh}, {6'h00, ~ddr, vals[i][7]});
        chk({1'b0, fb_en, pair_en}, {1'b0, vals[i][6:0]});
        host.rd(ccwr_pkg::MEM_OFF, rb);
        chk(rb, vals[i]);
      end
    end
    $display("test memory done");

    // Shared pin role, revert choice, alarm bit write ignored.
    host.wr(ccwr_pkg::WDOG_OFF, 8'h80);
    pin = 1'b0;
    settle();
    chk({6'h00, rst_oe, pd_n}, 8'h00);
    pin = 1'b1;
    settle();
    chk({6'h00, rst_oe, pd_n}, 8'h01);
    host.wr(ccwr_pkg::WDOG_OFF, 8'h50);
    pin = 1'b0;
    settle();
    chk({5'h00, rst_oe, pd_n, rev_sw}, 8'h07);
    host.rd(ccwr_pkg::WDOG_OFF, rb);
    chk(rb, 8'h40);
    $display("test watchdog byte done");

    // Divider from register, then MSB alone, then from ROM.
    dsel = 1'b1;
    host.wr(ccwr_pkg::NDIV_OFF, 8'hD5);
    chk({1'b0, pll_n}, 8'h55);
    host.wr(ccwr_pkg::NDIV_OFF, 8'h40);
    chk({1'b0, pll_n}, 8'h40);
    host.rd(ccwr_pkg::NDIV_OFF, rb);
    chk(rb, 8'h40);
    dsel = 1'b0;
    @(negedge clk_sys_i);
    chk({1'b0, pll_n}, {1'b0, rom_n});
    $display("test divider done");

    // Watchdog at the shortest and longest timeout codes.
    for (int k = 0; k < 2; k++) begin
      code   = (k == 0) ? 4'h1 : 4'hF;
      rv_base = rv_cnt;
      host.wr(ccwr_pkg::WDOG_OFF, {4'h4, code});
      @(negedge clk_sys_i);
      freq = 1'b1;
      @(negedge clk_sys_i);
      freq = 1'b0;
      wd_expiry(TICK * code);
      chk(8'(rv_cnt - rv_base), 8'h00);
      wd_expiry(TICK * code - 8);
      chk(8'(rv_cnt - rv_base), 8'h01);
      host.rd(ccwr_pkg::WDOG_OFF, rb);
      chk(rb, {4'h5, code});
      host.wr(ccwr_pkg::WDOG_OFF, 8'h40);
      chk({7'h00, flag}, 8'h00);
      fall_base = falls;
      freq  = 1'b1;
      @(negedge clk_sys_i);
      freq  = 1'b0;
      repeat (TICK * 16 + 20) @(negedge clk_sys_i);
      chk(8'(falls - fall_base), 8'h00);
    end
    $display("test watchdog timer done");
    final_report();
  end

endmodule // tb
